/* File: rtl/pbmc_mii_path.sv */
// MAC-side data path: loopback, isolate, collision test
`timescale 1ns/1ns
module pbmc_mii_path
  import pbmc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         loopback,
  input  wire logic         isolate,
  input  wire logic         col_test,
  input  wire logic         power_down,
  input  pbmc_mii_tx_s      mac_tx,
  input  pbmc_mii_rx_s      phy_rx,
  output pbmc_mii_rx_s      mac_rx,
  output pbmc_mii_tx_s      phy_tx
);

  typedef struct packed {
    pbmc_mii_rx_s rx;
    pbmc_mii_tx_s tx;
  } pbmc_path_s;

  pbmc_path_s s;
  pbmc_path_s next_s;

  always_comb begin
    next_s.rx = phy_rx;
    next_s.tx = mac_tx;
    if (loopback) begin
      // Transmit data turned back to the MAC; line side idle
      next_s.rx.rxd   = mac_tx.txd;
      next_s.rx.rx_dv = mac_tx.tx_en;
      next_s.rx.rx_er = mac_tx.tx_er;
      next_s.rx.crs   = mac_tx.tx_en;
      next_s.rx.col   = 1'b0;
      next_s.tx       = '0;
    end
    if (col_test) begin
      next_s.rx.col = mac_tx.tx_en;
    end
    if (isolate || power_down) begin
      // MAC interface released; line side quiet
      next_s.rx = '0;
      next_s.tx = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mac_rx = s.rx;
  assign phy_tx = s.tx;

endmodule

/* File: rtl/pbmc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pbmc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
      } st_t;
      st_t s;
      st_t next_s;

      always_comb begin
        next_s    = s;
        next_s.s1 = d[i];
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        // Change accepted only when stages two and three agree
        if (s.s2 == s.s3) begin
          next_s.q = s.s3;
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s <= '{INIT[i], INIT[i], INIT[i], INIT[i]};
        end else begin
          s <= next_s;
        end
      end

      assign q[i] = s.q;
    end
  endgenerate

endmodule

/* File: rtl/pbmc_top.sv */
// Basic mode control register with strap loading and MAC path control
`timescale 1ns/1ns
`include "pbmc_consts.svh"
module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int SRST_CYC = `PBMC_SRST_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // Register port
  input  wire logic [`PBMC_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // Pins and straps
  input  wire logic                   pin_mode_extended,
  input  wire logic                   pin_rmii_master,
  input  wire logic                   strap_autoneg,
  input  wire logic                   strap_speed,
  input  wire logic                   strap_duplex,
  input  wire logic                   strap_isolate,
  input  wire logic                   interrupt_powerdown_pin_n,
  // Negotiation engine
  input  wire logic                   an_speed_100,
  input  wire logic                   an_full_duplex,
  input  wire logic                   an_started,
  output logic                        an_enable,
  output logic                        an_restart_req,
  // Port control
  output logic                        pcs_soft_reset,
  output logic                        link_speed_100,
  output logic                        link_full_duplex,
  output logic                        power_down,
  output logic                        isolate,
  output logic                        ref_clk_out_en,
  // MAC and PCS data
  input  pbmc_mii_tx_s                mac_tx,
  input  pbmc_mii_rx_s                phy_rx,
  output pbmc_mii_rx_s                mac_rx,
  output pbmc_mii_tx_s                phy_tx
);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  pbmc_pins_s pins_raw;
  pbmc_pins_s pins;
  logic [`PBMC_SYNC_W-1:0] pins_q;

  assign pins_raw = '{
    pd_pin_n:      interrupt_powerdown_pin_n,
    mode_extended: pin_mode_extended,
    rmii_master:   pin_rmii_master,
    autoneg:       strap_autoneg,
    speed:         strap_speed,
    duplex:        strap_duplex,
    isolate:       strap_isolate
  };

  pbmc_sync #(
    .W    (`PBMC_SYNC_W),
    .INIT (`PBMC_SYNC_INIT)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (pins_raw),
    .q      (pins_q)
  );

  assign pins = pbmc_pins_s'(pins_q);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pbmc_state_e              state;
    logic [`PBMC_CNT_W-1:0]   cnt;
    pbmc_basic_mode_control_s               basic_mode_control;
    logic [15:0]              rdata;
    logic                     speed_100;
    logic                     full_duplex;
    logic                     ref_clk_en;
  } pbmc_top_s;

  pbmc_top_s s;
  pbmc_top_s next_s;

  logic       sel;
  logic       wr_hit;
  logic       pd_pin_active;
  pbmc_basic_mode_control_s wr_val;

  assign sel           = (reg_addr == `PBMC_ADDR_BASIC_MODE_CONTROL);
  assign wr_hit        = reg_wr && sel;
  assign wr_val        = pbmc_basic_mode_control_s'(reg_wdata);
  assign pd_pin_active = pins.mode_extended && !pins.pd_pin_n;

  // Default contents with strapped fields applied
  function automatic pbmc_basic_mode_control_s strapped(input pbmc_pins_s p);
    pbmc_basic_mode_control_s v;
    v           = pbmc_basic_mode_control_s'(`PBMC_RESET_VAL);
    v.an_enable = p.autoneg;
    if (!p.mode_extended) begin
      v.speed_100   = p.speed;
      v.full_duplex = p.duplex;
      v.isolate     = p.isolate;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Read data valid in the cycle after the strobe only
    next_s.rdata = '0;
    if (reg_rd && sel) begin
      next_s.rdata = 16'(s.basic_mode_control);
    end

    // Restart clears once negotiation begins, in any state
    if (an_started) begin
      next_s.basic_mode_control.an_restart = 1'b0;
    end

    unique case (s.state)
      PBMC_ST_STRAP: begin
        // Wait for the synchronisers to settle before latching straps
        next_s.cnt = s.cnt + `PBMC_CNT_W'(1);
        if (s.cnt == `PBMC_STRAP_WAIT) begin
          next_s.basic_mode_control  = strapped(pins);
          next_s.cnt   = '0;
          next_s.state = PBMC_ST_RUN;
        end
      end

      PBMC_ST_RUN: begin
        if (wr_hit) begin
          next_s.basic_mode_control.loopback    = wr_val.loopback;
          next_s.basic_mode_control.speed_100   = wr_val.speed_100;
          next_s.basic_mode_control.an_enable   = wr_val.an_enable;
          next_s.basic_mode_control.power_down  = wr_val.power_down;
          next_s.basic_mode_control.isolate     = wr_val.isolate;
          next_s.basic_mode_control.full_duplex = wr_val.full_duplex;
          next_s.basic_mode_control.col_test    = wr_val.col_test;
          if (wr_val.soft_reset) begin
            next_s.basic_mode_control.soft_reset = 1'b1;
            next_s.cnt             = '0;
            next_s.state           = PBMC_ST_SRST;
          end
        end
        // A write of one wins over the clear
        if (wr_hit && wr_val.an_restart) begin
          next_s.basic_mode_control.an_restart = 1'b1;
        end
        if (!next_s.basic_mode_control.an_enable) begin
          next_s.basic_mode_control.an_restart = 1'b0;
        end
      end

      PBMC_ST_SRST: begin
        // Writes are dropped while the reset runs
        next_s.cnt = s.cnt + `PBMC_CNT_W'(1);
        if (s.cnt == `PBMC_CNT_W'(SRST_CYC - 1)) begin
          next_s.basic_mode_control  = strapped(pins);
          next_s.cnt   = '0;
          next_s.state = PBMC_ST_RUN;
        end
      end

      default: begin
        // Illegal code: reload the straps
        next_s.cnt   = '0;
        next_s.state = PBMC_ST_STRAP;
      end
    endcase

    // Low power-down pin forces the bit in extended mode only; set wins over any write
    if (pd_pin_active) begin
      next_s.basic_mode_control.power_down = 1'b1;
    end

    next_s.basic_mode_control.rsvd = `PBMC_RSVD_ZERO;

    // Effective speed and duplex
    if (next_s.basic_mode_control.an_enable) begin
      next_s.speed_100   = an_speed_100;
      next_s.full_duplex = an_full_duplex;
    end else begin
      next_s.speed_100   = next_s.basic_mode_control.speed_100;
      next_s.full_duplex = next_s.basic_mode_control.full_duplex;
    end

    next_s.ref_clk_en = !(next_s.basic_mode_control.isolate && pins.rmii_master);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s             <= '0;
      s.state       <= PBMC_ST_STRAP;
      s.basic_mode_control        <= pbmc_basic_mode_control_s'(`PBMC_RESET_VAL);
      s.speed_100   <= 1'b1;
      s.ref_clk_en  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata        = s.rdata;
  assign an_enable        = s.basic_mode_control.an_enable;
  assign an_restart_req   = s.basic_mode_control.an_restart;
  assign pcs_soft_reset   = (s.state == PBMC_ST_SRST);
  assign link_speed_100   = s.speed_100;
  assign link_full_duplex = s.full_duplex;
  assign power_down       = s.basic_mode_control.power_down;
  assign isolate          = s.basic_mode_control.isolate;
  assign ref_clk_out_en   = s.ref_clk_en;

  pbmc_mii_path u_path (
    .clk        (clk),
    .arst_n     (arst_n),
    .loopback   (s.basic_mode_control.loopback),
    .isolate    (s.basic_mode_control.isolate),
    .col_test   (s.basic_mode_control.col_test),
    .power_down (s.basic_mode_control.power_down),
    .mac_tx     (mac_tx),
    .phy_rx     (phy_rx),
    .mac_rx     (mac_rx),
    .phy_tx     (phy_tx)
  );

endmodule

/* File: shared/pbmc_consts.svh */
// Constants of the basic mode control register block
`ifndef PBMC_CONSTS_SVH
`define PBMC_CONSTS_SVH

`define PBMC_ADDR_W        5
`define PBMC_ADDR_BASIC_MODE_CONTROL     5'h00
`define PBMC_RESET_VAL     16'h3000
`define PBMC_RSVD_ZERO     7'h00
`define PBMC_CLK_NS        50
`define PBMC_SRST_NS       800
`define PBMC_SRST_CYC      ((`PBMC_SRST_NS + `PBMC_CLK_NS - 1) / `PBMC_CLK_NS)
`define PBMC_CNT_W         8
`define PBMC_STRAP_WAIT    8'h04
`define PBMC_SYNC_W        7
`define PBMC_SYNC_INIT     7'h40

`endif

/* File: shared/pbmc_pkg.sv */
// Types of the basic mode control register block
package pbmc_pkg;

  typedef struct packed {
    logic       soft_reset;
    logic       loopback;
    logic       speed_100;
    logic       an_enable;
    logic       power_down;
    logic       isolate;
    logic       an_restart;
    logic       full_duplex;
    logic       col_test;
    logic [6:0] rsvd;
  } pbmc_basic_mode_control_s;

  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
  } pbmc_mii_tx_s;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
  } pbmc_mii_rx_s;

  // Synchronised pins: power-down pin, mode, RMII master, straps
  typedef struct packed {
    logic pd_pin_n;
    logic mode_extended;
    logic rmii_master;
    logic autoneg;
    logic speed;
    logic duplex;
    logic isolate;
  } pbmc_pins_s;

  typedef enum logic [1:0] {
    PBMC_ST_STRAP = 2'h0,
    PBMC_ST_RUN   = 2'h1,
    PBMC_ST_SRST  = 2'h3
  } pbmc_state_e;

endpackage

/* File: testbench/pbmc_checker.sv */
// Port assertions for the basic mode control block
`timescale 1ns/1ns
module pbmc_checker
  import pbmc_pkg::*;
(
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic         reg_rd,
  input wire logic         reg_wr,
  input wire logic  [15:0] reg_rdata,
  input wire logic         an_enable,
  input wire logic         an_restart_req,
  input wire logic         an_started,
  input wire logic         an_speed_100,
  input wire logic         an_full_duplex,
  input wire logic         link_speed_100,
  input wire logic         link_full_duplex,
  input wire logic         pcs_soft_reset,
  input wire logic         power_down,
  input wire logic         isolate,
  input wire logic         ref_clk_out_en,
  input pbmc_mii_rx_s      mac_rx,
  input pbmc_mii_tx_s      phy_tx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  rd_slot_a: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside read slot");
  rsvd_zero_a: assert property (reg_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  restart_off_a: assert property (!an_enable |-> !an_restart_req)
    else $error("restart set with negotiation off");
  restart_clr_a: assert property (an_restart_req && an_started && !reg_wr |=> !an_restart_req)
    else $error("restart not cleared");
  srst_end_a: assert property ($rose(pcs_soft_reset) |-> ##[1:40] !pcs_soft_reset)
    else $error("soft reset never ends");
  iso_clk_a: assert property (!ref_clk_out_en |-> isolate || $past(isolate))
    else $error("reference clock stopped without isolate");
  iso_quiet_a: assert property (isolate && $past(isolate) |-> mac_rx == '0 && phy_tx == '0)
    else $error("data path active while isolated");
  pd_quiet_a: assert property (power_down && $past(power_down) |-> mac_rx == '0 && phy_tx == '0)
    else $error("data path active while powered down");
  an_follow_a: assert property ($past(arst_n) && an_enable
    |-> {link_speed_100, link_full_duplex} == $past({an_speed_100, an_full_duplex}))
    else $error("link mode not from negotiation");
endmodule

bind pbmc_top pbmc_checker chk_u (.*);

/* File: testbench/pbmc_far_model.sv */
// Negotiation engine and receive source facing the control block
`timescale 1ns/1ns
module pbmc_far_model
  import pbmc_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic    clk,
  input  wire logic    arst_n,
  input  wire logic    an_restart_req,
  output logic         an_started,
  output logic         an_speed_100,
  output logic         an_full_duplex,
  output pbmc_mii_rx_s phy_rx
);
  logic [2:0] wait_cnt;

  // Results and receive data change every cycle so stale values show
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt       <= 3'h0;
      an_started     <= 1'b0;
      an_speed_100   <= 1'b0;
      an_full_duplex <= 1'b0;
      phy_rx         <= '0;
    end else begin
      an_started     <= an_restart_req && wait_cnt == DLY[2:0];
      wait_cnt       <= an_restart_req ? wait_cnt + 3'h1 : 3'h0;
      an_speed_100   <= ~an_speed_100;
      an_full_duplex <= an_speed_100;
      phy_rx         <= pbmc_mii_rx_s'(phy_rx + 8'h01);
    end
  end
endmodule

/* File: testbench/pbmc_tb_top.sv */
// Self-checking testbench for the basic mode control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module pbmc_tb_top
  import pbmc_pkg::*;
;
  logic         clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [4:0]   reg_addr = 5'h00;
  logic [15:0]  reg_wdata = 16'h0000, reg_rdata, exp_v;
  logic         pin_mode_extended = 1'b0, pin_rmii_master = 1'b1, strap_autoneg = 1'b1;
  logic         strap_speed = 1'b0, strap_duplex = 1'b1, strap_isolate = 1'b0, interrupt_powerdown_pin_n = 1'b1;
  logic         an_speed_100, an_full_duplex, an_started, an_enable, an_restart_req, pcs_soft_reset;
  logic         link_speed_100, link_full_duplex, power_down, isolate, ref_clk_out_en;
  pbmc_mii_tx_s mac_tx = '0, phy_tx;
  pbmc_mii_rx_s phy_rx, mac_rx;
  logic [15:0]  exp_q[$];
  int           failures = 0, n_checks = 0, n;

  always #25 clk = ~clk;

  pbmc_top #(.SRST_CYC(2)) dut_u (.*);
  pbmc_far_model far_u (.*);

  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
  endtask

  task automatic final_report();
    if (exp_q.size() != 0) failures++;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Read data appear in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, reg_rdata)
    end
  end

  initial begin
    void'($urandom(40));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 5'h00, 16'h1100);
    bus(1'b0, 5'h05, 16'h0000);
    $display("test straps done");
    bus(1'b1, 5'h00, 16'h03ff);
    bus(1'b0, 5'h00, 16'h0180);
    `CHK("speed", 1'b0, link_speed_100)
    `CHK("duplex", 1'b1, link_full_duplex)
    mac_tx.tx_en <= 1'b1;
    repeat (2) @(posedge clk);
    repeat (4) begin
      @(posedge clk);
      `CHK("col", 1'b1, mac_rx.col)
    end
    mac_tx.tx_en <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("col", 1'b0, mac_rx.col)
    $display("test forced mode done");
    // Selftest mode setting lies outside this block
    bus(1'b1, 5'h00, 16'h4000);
    repeat (6) begin
      @(posedge clk);
      mac_tx.txd <= 4'($urandom);
      repeat (2) @(posedge clk);
      `CHK("loop", mac_tx.txd, mac_rx.rxd)
    end
    $display("test loopback done");
    bus(1'b1, 5'h00, 16'h1000);
    bus(1'b1, 5'h00, 16'h1200);
    bus(1'b1, 5'h00, 16'h1000);
    bus(1'b0, 5'h00, 16'h1200);
    repeat (10) @(posedge clk);
    bus(1'b0, 5'h00, 16'h1000);
    $display("test restart done");
    bus(1'b1, 5'h00, 16'h1400);
    repeat (3) @(posedge clk);
    `CHK("refclk", 1'b0, ref_clk_out_en)
    pin_mode_extended <= 1'b1;
    interrupt_powerdown_pin_n <= 1'b0;
    bus(1'b1, 5'h00, 16'h1000);
    repeat (6) @(posedge clk);
    `CHK("pdown", 1'b1, power_down)
    bus(1'b0, 5'h00, 16'h1800);
    interrupt_powerdown_pin_n <= 1'b1;
    repeat (5) @(posedge clk);
    $display("test isolate and power-down done");
    bus(1'b1, 5'h00, 16'h8000);
    @(negedge clk);
    `CHK("srst", 1'b1, pcs_soft_reset)
    n = 0;
    while (pcs_soft_reset !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      failures++;
      final_report();
    end
    repeat (2) @(posedge clk);
    bus(1'b0, 5'h00, 16'h3000);
    repeat (2) @(posedge clk);
    $display("test soft reset done");
    pin_mode_extended <= 1'b0;
    strap_isolate     <= 1'b1;
    repeat (5) @(posedge clk);
    bus(1'b1, 5'h00, 16'h8000);
    repeat (4) @(posedge clk);
    bus(1'b0, 5'h00, 16'h1500);
    `CHK("refclk", 1'b0, ref_clk_out_en)
    repeat (2) @(posedge clk);
    $display("test strap reload done");
    final_report();
  end
endmodule
